// ==== rtl/stdet_top.sv ====
// Soft trap detection: stack, math, DMA collision and generic soft traps.
// Assumes core signals arrive on clock_i; the USB table pointer is a pin input.
`timescale 1ns/10ps
`default_nettype none

module stdet_top
  import stdet_pkg::*;
(
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        reset_n_i,
  // Stack pointer and limit
  input  wire logic        sp_write_i,
  input  wire logic [15:0] sp_wdata_i,
  input  wire logic        stack_limit_reg_write_i,
  input  wire logic [15:0] stack_limit_reg_wdata_i,
  input  wire logic        stack_ea_valid_i,
  input  wire logic [15:0] stack_ea_i,
  input  wire logic        stack_ea_wrap_i,
  // Accumulator arithmetic
  input  wire logic        acc_a_carry31_i,
  input  wire logic        acc_b_carry31_i,
  input  wire logic        acc_a_carry39_i,
  input  wire logic        acc_b_carry39_i,
  input  wire logic        acc_a_sat31_i,
  input  wire logic        acc_b_sat31_i,
  input  wire logic        acc_a_sat39_i,
  input  wire logic        acc_b_sat39_i,
  input  wire logic        acc_a_overflow_status_i,
  input  wire logic        acc_b_overflow_status_i,
  input  wire logic        divide_valid_i,
  input  wire logic        divide_first_iter_i,
  input  wire logic        divisor_zero_i,
  input  wire logic        accumulator_shift_op_i,
  input  wire logic [5:0]  shift_amount_i,
  // Trap control bits written by software
  input  wire logic        acc_a_ovf_trap_en_i,
  input  wire logic        acc_b_ovf_trap_en_i,
  input  wire logic        catastrophic_ovf_trap_en_i,
  input  wire logic        flag_clear_i,
  input  wire logic [9:0]  flag_clear_mask_i,
  // DMA and USB
  input  wire logic        cpu_write_i,
  input  wire logic [15:0] cpu_waddr_i,
  input  wire logic        dma_write_i,
  input  wire logic [15:0] dma_waddr_i,
  input  wire logic        dma_unimpl_access_i,
  input  wire logic        usb_ptr_unimpl_i,
  // Hardware loops
  input  wire logic        loop_start_i,
  input  wire logic        loop_end_i,
  // Generic soft trap sources
  input  wire logic [15:0] soft_trap_sources_reg_i,
  // CPU priority and acknowledge
  input  wire logic [3:0]  cpu_priority_i,
  input  wire logic        trap_done_i,
  // Stack state
  output var  logic [15:0] stack_pointer_wreg_o,
  output var  logic [15:0] stack_limit_reg_o,
  output var  logic        stack_limit_armed_o,
  // Status flags and loop nesting level
  output var  logic        stack_error_flag_o,
  output var  logic        math_error_flag_o,
  output var  logic        acc_a_ovf_flag_o,
  output var  logic        acc_b_ovf_flag_o,
  output var  logic        acc_a_catastrophic_flag_o,
  output var  logic        acc_b_catastrophic_flag_o,
  output var  logic        divide_zero_flag_o,
  output var  logic        shift_range_error_flag_o,
  output var  logic        dma_collision_error_flag_o,
  output var  logic        usb_address_error_flag_o,
  output var  logic        dma_address_error_flag_o,
  output var  logic        loop_stack_overflow_flag_o,
  output var  logic [2:0]  loop_nest_level_o,
  // Datapath effects
  output var  logic        acc_write_block_o,
  output var  logic        dma_write_discard_o,
  // Trap request
  output var  logic        trap_req_o,
  output var  logic [3:0]  trap_priority_o
);

  // ****************************************************************
  // Input conditioning
  // ****************************************************************

  logic usb_ptr_unimpl_s;

  stdet_sync u_usb_sync
  (
    .clock_i   (clock_i),
    .reset_n_i (reset_n_i),
    .d_i       (usb_ptr_unimpl_i),
    .q_o       (usb_ptr_unimpl_s)
  );

  // ****************************************************************
  // Event detection
  // ****************************************************************

  // Clear mask bit order: stack, math, ovfA, ovfB, catA, catB, div0,
  // shift, dma collision, then usb, dma address and loop overflow all on bit 9.
  logic        stack_ev;
  logic        ovf_a_ev;
  logic        ovf_b_ev;
  logic        cat_a_ev;
  logic        cat_b_ev;
  logic        div0_ev;
  logic        shift_ev;
  logic        math_ev;
  logic        coll_ev;
  logic        loop_ovf_ev;
  logic        math_cause;
  logic [5:0]  shift_mag;
  logic [9:0]  clr;
  logic [15:0] nxt_stack_limit_reg;

  assign stack_ev = (stack_ea_valid_i && stack_ea_wrap_i)
                  || (stack_ea_valid_i && stack_limit_armed_o
                      && (stack_ea_i > stack_limit_reg_o))
                  || (stack_pointer_wreg_o < STDET_SP_FLOOR);
  assign ovf_a_ev = acc_a_carry31_i && !acc_a_sat31_i && acc_a_ovf_trap_en_i;
  assign ovf_b_ev = acc_b_carry31_i && !acc_b_sat31_i && acc_b_ovf_trap_en_i;
  assign cat_a_ev = acc_a_carry39_i && !acc_a_sat31_i && !acc_a_sat39_i
                  && catastrophic_ovf_trap_en_i;
  assign cat_b_ev = acc_b_carry39_i && !acc_b_sat31_i && !acc_b_sat39_i
                  && catastrophic_ovf_trap_en_i;
  assign div0_ev  = divide_valid_i && divide_first_iter_i && divisor_zero_i;
  assign shift_mag = shift_amount_i[5] ? (6'h00 - shift_amount_i) : shift_amount_i;
  assign shift_ev = accumulator_shift_op_i
                  && (shift_mag > {1'b0, STDET_SHIFT_MAX});
  assign math_ev  = ovf_a_ev || ovf_b_ev || cat_a_ev || cat_b_ev
                  || div0_ev || shift_ev;
  assign coll_ev  = cpu_write_i && dma_write_i && (cpu_waddr_i == dma_waddr_i);
  assign loop_ovf_ev = loop_start_i && (loop_nest_level_o == STDET_LOOP_MAX);
  assign math_cause = acc_a_ovf_flag_o || acc_b_ovf_flag_o
                    || acc_a_catastrophic_flag_o || acc_b_catastrophic_flag_o
                    || divide_zero_flag_o || shift_range_error_flag_o
                    || acc_a_overflow_status_i || acc_b_overflow_status_i;
  assign clr = flag_clear_i ? flag_clear_mask_i : 10'h000;
  assign nxt_stack_limit_reg = stack_limit_reg_wdata_i;

  // ****************************************************************
  // Stack pointer, limit and loop level
  // ****************************************************************

  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      stack_pointer_wreg_o <= STDET_SP_RESET;
      stack_limit_reg_o    <= STDET_STACK_LIMIT_REG_RESET;
      stack_limit_armed_o  <= 1'b0;
      loop_nest_level_o    <= STDET_LOOP_RESET;
    end
    else
    begin
      if (sp_write_i)
      begin
        stack_pointer_wreg_o <= sp_wdata_i;
      end
      if (stack_limit_reg_write_i)
      begin
        stack_limit_reg_o   <= nxt_stack_limit_reg;
        stack_limit_armed_o <= 1'b1;
      end
      if (loop_start_i && !loop_ovf_ev)
      begin
        loop_nest_level_o <= loop_nest_level_o + 3'h1;
      end
      else if (loop_end_i && (loop_nest_level_o != STDET_LOOP_RESET))
      begin
        loop_nest_level_o <= loop_nest_level_o - 3'h1;
      end
    end
  end

  // ****************************************************************
  // Sticky status flags; a set wins over a clear in the same cycle
  // ****************************************************************

  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      stack_error_flag_o         <= 1'b0;
      math_error_flag_o          <= 1'b0;
      acc_a_ovf_flag_o           <= 1'b0;
      acc_b_ovf_flag_o           <= 1'b0;
      acc_a_catastrophic_flag_o  <= 1'b0;
      acc_b_catastrophic_flag_o  <= 1'b0;
      divide_zero_flag_o         <= 1'b0;
      shift_range_error_flag_o   <= 1'b0;
      dma_collision_error_flag_o <= 1'b0;
      usb_address_error_flag_o   <= 1'b0;
      dma_address_error_flag_o   <= 1'b0;
      loop_stack_overflow_flag_o <= 1'b0;
    end
    else
    begin
      stack_error_flag_o <= stack_ev || (stack_error_flag_o && !clr[0]);
      math_error_flag_o  <= math_ev
                         || (math_error_flag_o && !(clr[1] && !math_cause));
      acc_a_ovf_flag_o   <= ovf_a_ev || (acc_a_ovf_flag_o && !clr[2]);
      acc_b_ovf_flag_o   <= ovf_b_ev || (acc_b_ovf_flag_o && !clr[3]);
      acc_a_catastrophic_flag_o <= cat_a_ev || (acc_a_catastrophic_flag_o && !clr[4]);
      acc_b_catastrophic_flag_o <= cat_b_ev || (acc_b_catastrophic_flag_o && !clr[5]);
      divide_zero_flag_o <= div0_ev || (divide_zero_flag_o && !clr[6]);
      shift_range_error_flag_o <= shift_ev || (shift_range_error_flag_o && !clr[7]);
      dma_collision_error_flag_o <= coll_ev
                                 || (dma_collision_error_flag_o && !clr[8]);
      usb_address_error_flag_o <= usb_ptr_unimpl_s
                               || (usb_address_error_flag_o && !clr[9]);
      dma_address_error_flag_o <= dma_unimpl_access_i
                               || (dma_address_error_flag_o && !clr[9]);
      loop_stack_overflow_flag_o <= loop_ovf_ev
                                 || (loop_stack_overflow_flag_o && !clr[9]);
    end
  end

  // ****************************************************************
  // Datapath side effects
  // ****************************************************************

  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      acc_write_block_o   <= 1'b0;
      dma_write_discard_o <= 1'b0;
    end
    else
    begin
      acc_write_block_o   <= shift_ev;
      dma_write_discard_o <= coll_ev;
    end
  end

  // ****************************************************************
  // Priority selection and request sequencing
  // ****************************************************************

  logic                   generic_pend;
  logic [STDET_NSRC-1:0]  pend;
  logic [3:0]             best_pri;
  logic [3:0]             pri_tab [STDET_NSRC];
  logic [3:0]             pick [STDET_NSRC+1];
  stdet_state_t           state_ff;
  stdet_state_t           nxt_state;
  logic [3:0]             held_pri_ff;

  assign generic_pend = |soft_trap_sources_reg_i;
  // Soft sources are usb, dma address and loop overflow combined into generic.
  assign pend = {generic_pend || usb_address_error_flag_o
                   || dma_address_error_flag_o || loop_stack_overflow_flag_o,
                 stack_error_flag_o, math_error_flag_o,
                 dma_collision_error_flag_o};
  assign pri_tab[0] = STDET_PRI_DMA;
  assign pri_tab[1] = STDET_PRI_MATH;
  assign pri_tab[2] = STDET_PRI_STACK;
  assign pri_tab[3] = STDET_PRI_GENERIC;
  assign pick[0] = STDET_PRI_NONE;

  // Higher index is higher priority, so later entries override.
  genvar gi;
  generate
    for (gi = 0; gi < STDET_NSRC; gi++)
    begin : g_pri
      assign pick[gi+1] = pend[gi] ? pri_tab[gi] : pick[gi];
    end
  endgenerate

  assign best_pri = pick[STDET_NSRC];

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      STDET_IDLE:
      begin
        if ((best_pri >= STDET_PRI_TRAP_BASE) && (best_pri > cpu_priority_i))
        begin
          nxt_state = STDET_SAMPLE;
        end
      end
      STDET_SAMPLE:
      begin
        nxt_state = STDET_PRESENT;
      end
      STDET_PRESENT:
      begin
        if (trap_done_i)
        begin
          nxt_state = STDET_IDLE;
        end
      end
      default:
      begin
        nxt_state = STDET_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state_ff        <= STDET_IDLE;
      held_pri_ff     <= STDET_PRI_NONE;
      trap_req_o      <= 1'b0;
      trap_priority_o <= STDET_PRI_NONE;
    end
    else
    begin
      state_ff <= nxt_state;
      if (state_ff == STDET_IDLE)
      begin
        held_pri_ff <= best_pri;
      end
      trap_req_o      <= (nxt_state == STDET_PRESENT);
      trap_priority_o <= (nxt_state == STDET_PRESENT) ? held_pri_ff : STDET_PRI_NONE;
    end
  end

endmodule // stdet_top

`default_nettype wire

// ==== rtl/stdet_pkg.sv ====
// Constants shared by the soft trap detection block.
// Assumes a 16-bit data space and a 50 MHz core clock.
package stdet_pkg;

  localparam logic [15:0] STDET_SP_RESET      = 16'h1000;
  localparam logic [15:0] STDET_SP_FLOOR      = 16'h1000;
  localparam logic [15:0] STDET_STACK_LIMIT_REG_RESET   = 16'h0000;
  localparam logic [2:0]  STDET_LOOP_MAX      = 3'h4;
  localparam logic [2:0]  STDET_LOOP_RESET    = 3'h0;
  localparam logic [4:0]  STDET_SHIFT_MAX     = 5'h10;
  localparam int          STDET_USB_ALIGN_W   = 9;
  localparam logic [3:0]  STDET_PRI_DMA       = 4'hA;
  localparam logic [3:0]  STDET_PRI_MATH      = 4'hB;
  localparam logic [3:0]  STDET_PRI_STACK     = 4'hC;
  localparam logic [3:0]  STDET_PRI_GENERIC   = 4'hD;
  localparam logic [3:0]  STDET_PRI_NONE      = 4'h0;
  localparam logic [3:0]  STDET_PRI_TRAP_BASE = 4'h8;
  localparam int          STDET_ACK_CYCLES    = 2;
  localparam int          STDET_NSRC          = 4;

  typedef enum logic [1:0] {
    STDET_IDLE,
    STDET_SAMPLE,
    STDET_PRESENT
  } stdet_state_t;

endpackage

// ==== rtl/stdet_sync.sv ====
// Four-flop input conditioner for a pin-level signal: three stages and a registered output.
// Assumes a single clock; output changes once flops two and three agree.
`timescale 1ns/10ps
`default_nettype none

module stdet_sync
(
  // Clock and reset
  input  wire logic clock_i,
  input  wire logic reset_n_i,
  // Data
  input  wire logic d_i,
  output var  logic q_o
);

  logic s1_ff;
  logic s2_ff;
  logic s3_ff;

  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
      q_o   <= 1'b0;
    end
    else
    begin
      s1_ff <= d_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff)
      begin
        q_o <= s3_ff;
      end
    end
  end

endmodule // stdet_sync

`default_nettype wire

// ==== tb/stdet_cpu_model.sv ====
// Model of the CPU exception sequencer that faces the trap request.
// Assumes one clock; acknowledges a presented trap after a set wait.
`timescale 1ns/10ps
`default_nettype none
module stdet_cpu_model
(
  // Clock and reset
  input  wire logic       clock_i,
  input  wire logic       reset_n_i,
  // Trap handshake
  input  wire logic       trap_req_i,
  input  wire logic [3:0] wait_cycles_i,
  output var  logic       trap_done_o
);
  logic [3:0] wait_ff;
  // One acknowledge per wait; the count then restarts even if the request stays high.
  always_ff @(posedge clock_i or negedge reset_n_i)
    if (!reset_n_i)
    begin
      wait_ff     <= 4'h0;
      trap_done_o <= 1'b0;
    end
    else
    begin
      trap_done_o <= 1'b0;
      if (!trap_req_i || trap_done_o) wait_ff <= 4'h0;
      else if (wait_ff == wait_cycles_i) trap_done_o <= 1'b1;
      else wait_ff <= wait_ff + 4'h1;
    end
endmodule // stdet_cpu_model
`default_nettype wire

// ==== tb/stdet_assertions.sv ====
// Concurrent checks on the ports of the soft trap detection block.
// Assumes it is bound to stdet_top and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module stdet_assertions
(
  // Inputs of the block, and trap_priority_o
  input wire logic clock_i, reset_n_i, stack_ea_valid_i, stack_ea_wrap_i,
  input wire logic acc_a_carry31_i, acc_a_sat31_i, divide_valid_i,
  input wire logic divide_first_iter_i, divisor_zero_i, accumulator_shift_op_i,
  input wire logic flag_clear_i, cpu_write_i, dma_write_i, loop_start_i,
  input wire logic loop_end_i, trap_done_i, acc_a_overflow_status_i,
  input wire logic [5:0] shift_amount_i,
  input wire logic [9:0] flag_clear_mask_i,
  input wire logic [15:0] cpu_waddr_i, dma_waddr_i,
  input wire logic [3:0] cpu_priority_i, trap_priority_o,
  // Outputs of the block
  input wire logic stack_error_flag_o, math_error_flag_o, acc_a_ovf_flag_o,
  input wire logic divide_zero_flag_o, shift_range_error_flag_o,
  input wire logic acc_write_block_o, dma_write_discard_o, trap_req_o,
  input wire logic dma_collision_error_flag_o, loop_stack_overflow_flag_o,
  input wire logic [2:0] loop_nest_level_o
);
  wire logic [5:0] shift_mag = shift_amount_i[5] ? -shift_amount_i : shift_amount_i;
  wire logic       shift_bad = accumulator_shift_op_i && (shift_mag > 6'h10);
  sequence s_div0;
    divide_valid_i && divide_first_iter_i && divisor_zero_i;
  endsequence
  sequence s_collide;
    cpu_write_i && dma_write_i && (cpu_waddr_i == dma_waddr_i);
  endsequence
  default clocking @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  chk_stack_wrap: assert property (stack_ea_valid_i && stack_ea_wrap_i |=>
    stack_error_flag_o) else $error("stack wrap did not set the stack flag");
  chk_stack_sticky: assert property ($fell(stack_error_flag_o) |->
    $past(flag_clear_i && flag_clear_mask_i[0])) else $error("stack flag lost");
  chk_ovf_sat: assert property ($rose(acc_a_ovf_flag_o) |->
    $past(acc_a_carry31_i && !acc_a_sat31_i)) else $error("bad overflow A flag");
  chk_div_zero: assert property (s_div0 |=>
    divide_zero_flag_o && math_error_flag_o) else $error("divide by zero missed");
  chk_shift_range: assert property (shift_bad |=>
    acc_write_block_o && shift_range_error_flag_o) else $error("shift range missed");
  chk_math_hold: assert property (math_error_flag_o && acc_a_overflow_status_i
    |=> math_error_flag_o) else $error("math flag cleared while cause stands");
  chk_dma_collide: assert property (s_collide |=>
    dma_write_discard_o && dma_collision_error_flag_o) else $error("collision missed");
  chk_loop_cap: assert property (loop_nest_level_o == 3'h4 && loop_start_i
    && !loop_end_i |=> loop_nest_level_o == 3'h4 && loop_stack_overflow_flag_o)
    else $error("loop overflow handled wrongly");
  chk_req_prio: assert property ($rose(trap_req_o) |-> trap_priority_o > cpu_priority_i
    && trap_priority_o >= 4'hA && trap_priority_o <= 4'hD) else $error("bad priority");
  chk_req_hold: assert property (trap_req_o && !trap_done_i |=>
    trap_req_o && $stable(trap_priority_o)) else $error("request not held");
  chk_req_drop: assert property (trap_req_o && trap_done_i |=> !trap_req_o)
    else $error("request not released after done");
  chk_req_cause: assert property ($rose(trap_req_o) && trap_priority_o == 4'hC
    |-> $past(stack_error_flag_o)) else $error("stack request came too early");
endmodule // stdet_assertions
bind stdet_top stdet_assertions u_chk (.*);
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench for the soft trap detection block.
// Assumes the CPU model acknowledges traps and software clears flags here.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import stdet_pkg::*;
  logic clock_i, reset_n_i = '0, sp_write_i = '0, stack_limit_reg_write_i = '0;
  logic stack_ea_valid_i = '0, stack_ea_wrap_i = '0, acc_a_carry31_i = '0;
  logic acc_b_carry31_i = '0, acc_a_carry39_i = '0, acc_b_carry39_i = '0;
  logic acc_a_sat31_i = '0, acc_b_sat31_i = '0, acc_a_sat39_i = '0, acc_b_sat39_i = '0;
  logic acc_a_overflow_status_i = '0, acc_b_overflow_status_i = '0, divide_valid_i = '0;
  logic divide_first_iter_i = '0, divisor_zero_i = '0, accumulator_shift_op_i = '0;
  logic acc_a_ovf_trap_en_i = '0, acc_b_ovf_trap_en_i = '0, flag_clear_i = '0;
  logic catastrophic_ovf_trap_en_i = '0, cpu_write_i = '0, dma_write_i = '0;
  logic dma_unimpl_access_i = '0, usb_ptr_unimpl_i = '0, loop_start_i = '0, loop_end_i = '0;
  logic [15:0] sp_wdata_i = '0, stack_limit_reg_wdata_i = '0, stack_ea_i = '0, cpu_waddr_i = '0;
  logic [15:0] dma_waddr_i = '0, soft_trap_sources_reg_i = '0;
  logic [5:0]  shift_amount_i = '0;
  logic [9:0]  flag_clear_mask_i = '0;
  logic [3:0]  cpu_priority_i = '0, ack_wait = 4'h6;
  wire logic   trap_done_i;
  logic [15:0] stack_pointer_wreg_o, stack_limit_reg_o;
  logic [3:0]  trap_priority_o;
  logic [2:0]  loop_nest_level_o;
  logic stack_limit_armed_o, stack_error_flag_o, math_error_flag_o, acc_a_ovf_flag_o;
  logic acc_b_ovf_flag_o, acc_a_catastrophic_flag_o, acc_b_catastrophic_flag_o;
  logic divide_zero_flag_o, shift_range_error_flag_o, dma_collision_error_flag_o;
  logic usb_address_error_flag_o, dma_address_error_flag_o, loop_stack_overflow_flag_o;
  logic acc_write_block_o, dma_write_discard_o, trap_req_o;
  logic [5:0] sh_amt [4] = '{6'h10, 6'h11, 6'h30, 6'h2F};
  logic       sh_bad [4] = '{1'h0, 1'h1, 1'h0, 1'h1};
  int err_total = 0, checked = 0, cyc = 0;
  stdet_top dut (.*);
  stdet_cpu_model cpu (.clock_i(clock_i), .reset_n_i(reset_n_i), .trap_req_i(trap_req_o),
    .wait_cycles_i(ack_wait), .trap_done_o(trap_done_i));
  initial
  begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end
  task automatic chk_bit(string nm, logic exp, logic got);
    checked++;
    if (got !== exp) begin err_total++; $display("[FAIL] %s exp %h got %h", nm, exp, got); end
  endtask
  task automatic chk_val(string nm, logic [15:0] exp, logic [15:0] got);
    checked++;
    if (got !== exp) begin err_total++; $display("[FAIL] %s exp %h got %h", nm, exp, got); end
  endtask
  task automatic step(int n);
    repeat (n) @(negedge clock_i);
  endtask
  task automatic clr(logic [9:0] m);
    flag_clear_i = 1'b1;
    flag_clear_mask_i = m;
    @(negedge clock_i) flag_clear_i = 1'b0;
    flag_clear_mask_i = 10'h000;
  endtask
  // Waits for a presented trap, checks its level, clears the causes, waits for release.
  task automatic take(logic [3:0] pri, logic [9:0] m);
    repeat (30) if (!trap_req_o) @(negedge clock_i);
    chk_val("trap_priority", {12'h000, pri}, {12'h000, trap_priority_o});
    soft_trap_sources_reg_i = 16'h0000;
    clr(m);
    repeat (30) if (trap_req_o) @(negedge clock_i);
    chk_bit("trap_released", 1'b0, trap_req_o);
  endtask
  task automatic give_verdict;
    $display("checked=%0d err_total=%0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clock_i) if (++cyc == 20000) begin err_total++; give_verdict(); end
  initial
  begin
    step(6);
    reset_n_i = 1'b1;
    chk_val("sp_reset", STDET_SP_RESET, stack_pointer_wreg_o);
    chk_bit("armed_reset", 1'b0, stack_limit_armed_o);
    stack_ea_valid_i = 1'b1;
    stack_ea_i = 16'hFFF0;
    @(negedge clock_i) stack_ea_valid_i = 1'b0;
    step(1);
    chk_bit("stack_unarmed", 1'b0, stack_error_flag_o);
    stack_limit_reg_write_i = 1'b1;
    stack_limit_reg_wdata_i = 16'h2000;
    @(negedge clock_i) stack_limit_reg_write_i = 1'b0;
    chk_bit("armed", 1'b1, stack_limit_armed_o);
    chk_val("limit", 16'h2000, stack_limit_reg_o);
    foreach (sh_bad[i]) if (i < 2)
    begin
      stack_ea_valid_i = 1'b1;
      stack_ea_i = 16'h2000 + 16'(2 * i);
      @(negedge clock_i) stack_ea_valid_i = 1'b0;
      step(1);
      chk_bit("stack_above", sh_bad[i], stack_error_flag_o);
    end
    take(4'hC, 10'h000);
    take(4'hC, 10'h001);
    sp_write_i = 1'b1;
    sp_wdata_i = 16'h0FFE;
    @(negedge clock_i) sp_wdata_i = 16'h1000;
    @(negedge clock_i) sp_write_i = 1'b0;
    chk_bit("stack_floor", 1'b1, stack_error_flag_o);
    chk_val("sp_load", 16'h1000, stack_pointer_wreg_o);
    take(4'hC, 10'h001);
    stack_ea_valid_i = 1'b1;
    stack_ea_i = 16'h0002;
    stack_ea_wrap_i = 1'b1;
    @(negedge clock_i) stack_ea_valid_i = 1'b0;
    stack_ea_wrap_i = 1'b0;
    step(1);
    chk_bit("stack_wrap", 1'b1, stack_error_flag_o);
    take(4'hC, 10'h001);
    cpu_priority_i = 4'hC;
    {divide_valid_i, divide_first_iter_i, divisor_zero_i} = 3'h7;
    {cpu_write_i, dma_write_i, stack_ea_valid_i} = 3'h7;
    cpu_waddr_i = 16'h0800;
    dma_waddr_i = 16'h0800;
    stack_ea_i = 16'h3000;
    @(negedge clock_i) {divide_valid_i, cpu_write_i, dma_write_i, stack_ea_valid_i} = 4'h0;
    chk_bit("dma_discard", 1'b1, dma_write_discard_o);
    chk_bit("div_zero", 1'b1, divide_zero_flag_o);
    step(6);
    chk_bit("below_cpu", 1'b0, trap_req_o);
    cpu_priority_i = 4'h0;
    take(4'hC, 10'h001);
    clr(10'h002);
    chk_bit("math_kept", 1'b1, math_error_flag_o);
    take(4'hB, 10'h040);
    take(4'hB, 10'h002);
    take(4'hA, 10'h100);
    {cpu_write_i, dma_write_i, dma_waddr_i} = {2'h3, 16'h0802};
    @(negedge clock_i) {cpu_write_i, dma_write_i} = 2'h0;
    chk_bit("no_discard", 1'b0, dma_write_discard_o);
    step(8);
    chk_bit("idle", 1'b0, trap_req_o);
    {acc_a_ovf_trap_en_i, catastrophic_ovf_trap_en_i, acc_a_sat31_i} = 3'h7;
    {acc_a_carry31_i, acc_b_carry31_i, acc_b_sat39_i, acc_b_carry39_i} = 4'hF;
    @(negedge clock_i) {acc_a_carry31_i, acc_b_carry31_i, acc_b_carry39_i} = 3'h0;
    {acc_a_sat31_i, acc_b_sat39_i} = 2'h0;
    step(1);
    chk_bit("ovf_saturated", 1'b0, acc_a_ovf_flag_o);
    chk_bit("cat_saturated", 1'b0, acc_b_catastrophic_flag_o);
    chk_bit("ovf_b_gated", 1'b0, math_error_flag_o);
    chk_bit("ovf_b_flag", 1'b0, acc_b_ovf_flag_o);
    clr(10'h008);
    {acc_a_carry31_i, acc_b_carry39_i, acc_a_overflow_status_i} = 3'h7;
    {acc_b_ovf_trap_en_i, acc_b_carry31_i, acc_a_carry39_i, acc_a_sat39_i} = 4'hF;
    @(negedge clock_i) {acc_a_carry31_i, acc_b_carry39_i} = 2'h0;
    {acc_b_carry31_i, acc_a_carry39_i} = 2'h0;
    step(1);
    chk_bit("ovf_a", 1'b1, acc_a_ovf_flag_o);
    chk_bit("ovf_b", 1'b1, acc_b_ovf_flag_o);
    chk_bit("cat_a_saturated", 1'b0, acc_a_catastrophic_flag_o);
    chk_bit("cat_b", 1'b1, acc_b_catastrophic_flag_o);
    chk_bit("math_set", 1'b1, math_error_flag_o);
    take(4'hB, 10'h03C);
    clr(10'h002);
    chk_bit("math_oa_kept", 1'b1, math_error_flag_o);
    acc_a_overflow_status_i = 1'b0;
    take(4'hB, 10'h002);
    foreach (sh_amt[i])
    begin
      accumulator_shift_op_i = 1'b1;
      shift_amount_i = sh_amt[i];
      @(negedge clock_i) accumulator_shift_op_i = 1'b0;
      chk_bit("acc_block", sh_bad[i], acc_write_block_o);
      chk_bit("shift_flag", sh_bad[i], shift_range_error_flag_o);
      clr(10'h080);
    end
    take(4'hB, 10'h002);
    ack_wait = 4'h1;
    repeat (8) @(negedge clock_i) loop_start_i = ~loop_start_i;
    @(negedge clock_i) loop_start_i = 1'b0;
    chk_val("loop_level", 16'h0004, {13'h0000, loop_nest_level_o});
    chk_bit("loop_no_ovf", 1'b0, loop_stack_overflow_flag_o);
    @(negedge clock_i) loop_start_i = 1'b1;
    @(negedge clock_i) {loop_start_i, loop_end_i} = 2'h1;
    chk_val("loop_full", 16'h0004, {13'h0000, loop_nest_level_o});
    chk_bit("loop_ovf", 1'b1, loop_stack_overflow_flag_o);
    @(negedge clock_i) {loop_end_i, dma_unimpl_access_i, usb_ptr_unimpl_i} = 3'h3;
    chk_val("loop_pop", 16'h0003, {13'h0000, loop_nest_level_o});
    @(negedge clock_i) dma_unimpl_access_i = 1'b0;
    step(6);
    chk_bit("dma_addr", 1'b1, dma_address_error_flag_o);
    chk_bit("usb_addr", 1'b1, usb_address_error_flag_o);
    usb_ptr_unimpl_i = 1'b0;
    step(6);
    take(4'hD, 10'h200);
    cpu_priority_i = 4'hC;
    soft_trap_sources_reg_i = 16'h0004;
    take(4'hD, 10'h000);
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire
